/* logic/cmc_mode_ctrl.sv */
`timescale 1ns/10ps
module cmc_mode_ctrl (
	// clock, reset, enable
	input  logic                    core_clk,
	input  logic                    reset_n,
	input  logic                    clk_en,
	// register port
	input  logic [7:0]              reg_addr,
	input  logic [31:0]             reg_wdata,
	input  logic                    reg_wr,
	input  logic                    reg_rd,
	output logic [31:0]             reg_rdata,
	// bus pins
	output logic                    can_tx_pin,
	input  logic                    can_rx_pin,
	input  logic                    can_tx_pad_in,
	// protocol core bit path
	input  logic                    core_tx,
	output logic                    core_rx,
	input  logic                    bit_tick,
	output logic                    core_enable,
	output logic                    ack_err_ignore,
	output logic                    auto_retransmit,
	output logic [cmc_pkg::BTW-1:0] bit_timing,
	output logic                    bus_off,
	// error events from the core
	input  logic [3:0]              tec_inc,
	input  logic                    tec_dec,
	input  logic [3:0]              rec_inc,
	input  logic                    rec_dec,
	input  logic                    lec_valid,
	input  logic [2:0]              lec_code,
	// received frames
	input  logic                    rx_id_ready,
	input  logic                    rx_remote,
	input  logic [cmc_pkg::IDW-1:0] rx_id,
	input  logic [3:0]              rx_dlc,
	input  logic [63:0]             rx_data,
	input  logic                    rx_done,
	// frames to send
	output logic                    tx_request,
	input  logic                    tx_start,
	input  logic                    tx_ok,
	input  logic                    tx_fail,
	output logic [cmc_pkg::IDW-1:0] tx_id,
	output logic [3:0]              tx_dlc,
	output logic [63:0]             tx_data
);
	import cmc_pkg::*;

	typedef struct packed {
		cmc_state_t     st;
		logic           init;
		logic           nort;
		logic           cfg_en;
		logic           test;
		logic           arec;
		logic           silent;
		logic           ilb;
		logic           xlb;
		logic [BTW-1:0] btr;
		logic [31:0]    arec_dly;
		logic [31:0]    arec_cnt;
		logic [8:0]     tec;
		logic [7:0]     rec;
		logic [2:0]     lec;
		logic [3:0]     run;
		logic [7:0]     seqs;
		logic           tx_pin;
		logic           c_rx;
		logic [31:0]    rdata;
	} cmc_top_t;

	cmc_top_t    st_ff;
	cmc_top_t    nxt_st;
	logic        te;
	logic        sil;
	logic        lb;
	logic        xlb;
	logic        on_bus;
	logic        idle_seq;
	logic [9:0]  tec_sum;
	logic [8:0]  rec_sum;
	logic [31:0] obj_rdata;

	assign te = st_ff.test;
	assign sil = te & st_ff.silent;
	assign lb = te & st_ff.ilb;
	assign xlb = te & st_ff.xlb & ~lb;
	assign on_bus = (st_ff.st == ST_ACTIVE);
	assign core_enable = on_bus;
	assign ack_err_ignore = lb;
	assign auto_retransmit = ~st_ff.nort;
	assign bit_timing = st_ff.btr;
	assign can_tx_pin = st_ff.tx_pin;
	assign core_rx = st_ff.c_rx;
	assign reg_rdata = st_ff.rdata;
	assign bus_off = (st_ff.st == ST_BOFF) || (st_ff.st == ST_RECOV);
	// eleventh recessive bit in a row closes one idle run
	assign idle_seq = bit_tick && st_ff.c_rx && (st_ff.run == IDLE_RUN - 4'h1);
	assign tec_sum = {1'b0, st_ff.tec} + {6'h00, tec_inc}
		- {9'h000, (tec_dec && st_ff.tec != 9'h000)};
	assign rec_sum = {1'b0, st_ff.rec} + {5'h00, rec_inc}
		- {8'h00, (rec_dec && st_ff.rec != 8'h00)};

	cmc_obj_store u_objs (
		.core_clk           (core_clk),
		.reset_n            (reset_n),
		.clk_en             (clk_en),
		.xfer_en            (on_bus),
		.no_auto_retransmit (st_ff.nort),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.obj_rdata          (obj_rdata),
		.rx_id_ready        (rx_id_ready),
		.rx_remote          (rx_remote),
		.rx_id              (rx_id),
		.rx_dlc             (rx_dlc),
		.rx_data            (rx_data),
		.rx_done            (rx_done),
		.tx_request         (tx_request),
		.tx_start           (tx_start),
		.tx_ok              (tx_ok),
		.tx_fail            (tx_fail),
		.tx_id              (tx_id),
		.tx_dlc             (tx_dlc),
		.tx_data            (tx_data)
	);

	always_comb begin
		logic [31:0] rv;
		rv = '0;
		nxt_st = st_ff;

		// receive path into the core
		if (lb) begin
			nxt_st.c_rx = core_tx;
		end else if (xlb) begin
			nxt_st.c_rx = can_tx_pad_in;
		end else if (sil) begin
			nxt_st.c_rx = can_rx_pin & core_tx;
		end else begin
			nxt_st.c_rx = can_rx_pin;
		end
		// transmit pin stays recessive off the bus or when silent
		nxt_st.tx_pin = (on_bus && !sil) ? core_tx : 1'b1;

		// recessive run counter
		if (st_ff.st == ST_INIT || st_ff.st == ST_BOFF) begin
			nxt_st.run = '0;
		end else if (bit_tick) begin
			if (!st_ff.c_rx || idle_seq) begin
				nxt_st.run = '0;
			end else begin
				nxt_st.run = st_ff.run + 4'h1;
			end
		end

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				A_CTL: begin
					nxt_st.init = reg_wdata[C_INIT];
					nxt_st.nort = reg_wdata[C_NORT];
					nxt_st.cfg_en = reg_wdata[C_CFG];
					nxt_st.test = reg_wdata[C_TEST];
					nxt_st.arec = reg_wdata[C_AREC];
				end
				A_BTR: begin
					if (st_ff.init && st_ff.cfg_en) begin
						nxt_st.btr = reg_wdata[BTW-1:0];
					end
				end
				A_TEST: begin
					if (st_ff.test) begin
						nxt_st.silent = reg_wdata[T_SIL];
						nxt_st.ilb = reg_wdata[T_LB];
						nxt_st.xlb = reg_wdata[T_XLB];
					end
				end
				A_ABOD: nxt_st.arec_dly = reg_wdata;
				default: nxt_st.arec_dly = st_ff.arec_dly;
			endcase
		end

		// operating state; hardware updates follow software writes
		case (st_ff.st)
			ST_INIT: begin
				if (!st_ff.init) begin
					nxt_st.st = ST_SYNC;
				end
			end
			ST_SYNC: begin
				if (st_ff.init) begin
					nxt_st.st = ST_INIT;
				end else if (idle_seq) begin
					nxt_st.st = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (st_ff.init) begin
					nxt_st.st = ST_INIT;
				end else if (tec_sum >= TEC_LIM) begin
					nxt_st.st = ST_BOFF;
					nxt_st.init = 1'b1;
					nxt_st.arec_cnt = '0;
				end else begin
					nxt_st.tec = tec_sum[8:0];
					nxt_st.rec = rec_sum[8] ? 8'hFF : rec_sum[7:0];
					if (lec_valid) begin
						nxt_st.lec = lec_code;
					end
				end
			end
			ST_BOFF: begin
				if (!st_ff.init) begin
					nxt_st.st = ST_RECOV;
				end else if (st_ff.arec) begin
					nxt_st.arec_cnt = st_ff.arec_cnt + 32'h0000_0001;
					if (st_ff.arec_cnt >= st_ff.arec_dly) begin
						nxt_st.init = 1'b0;
						nxt_st.st = ST_RECOV;
					end
				end
			end
			ST_RECOV: begin
				if (idle_seq) begin
					nxt_st.lec = LEC_BIT0;
					nxt_st.seqs = st_ff.seqs + 8'h01;
					if (st_ff.seqs == RECOV_SEQS - 8'h01) begin
						nxt_st.seqs = '0;
						nxt_st.tec = '0;
						nxt_st.rec = '0;
						nxt_st.st = st_ff.init ? ST_INIT : ST_ACTIVE;
					end
				end
			end
			default: nxt_st.st = ST_INIT;
		endcase

		// register reads, data stands one cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				A_CTL: begin
					rv[C_INIT] = st_ff.init;
					rv[C_NORT] = st_ff.nort;
					rv[C_CFG] = st_ff.cfg_en;
					rv[C_TEST] = st_ff.test;
					rv[C_AREC] = st_ff.arec;
				end
				A_STAT: begin
					rv[S_LEC+2:S_LEC] = st_ff.lec;
					rv[S_BOFF] = bus_off;
					rv[S_REC] = (st_ff.st == ST_RECOV);
					rv[S_ON] = on_bus;
				end
				A_ERRC: begin
					rv[E_TEC+8:E_TEC] = st_ff.tec;
					rv[E_REC+7:E_REC] = st_ff.rec;
				end
				A_BTR: rv[BTW-1:0] = st_ff.btr;
				A_TEST: begin
					rv[T_SIL] = st_ff.silent;
					rv[T_LB] = st_ff.ilb;
					rv[T_XLB] = st_ff.xlb;
					rv[T_RXP] = can_rx_pin;
				end
				A_ABOD: rv = st_ff.arec_dly;
				A_OSEL, A_OID, A_OMSK, A_OCTL, A_ODLO, A_ODHI: rv = obj_rdata;
				default: rv = '0;
			endcase
		end
		nxt_st.rdata = rv;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st_ff <= '0;
			st_ff.st <= ST_INIT;
			st_ff.init <= INIT_RST;
			st_ff.btr <= BTR_RST;
			st_ff.arec_dly <= ABOD_RST;
			st_ff.tx_pin <= 1'b1;
			st_ff.c_rx <= 1'b1;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end
endmodule // cmc_mode_ctrl

/* logic/cmc_pkg.sv */
package cmc_pkg;
	// register offsets
	localparam logic [7:0] A_CTL  = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_ERRC = 8'h08;
	localparam logic [7:0] A_BTR  = 8'h0C;
	localparam logic [7:0] A_TEST = 8'h14;
	localparam logic [7:0] A_ABOD = 8'h18;
	localparam logic [7:0] A_OSEL = 8'h20;
	localparam logic [7:0] A_OID  = 8'h24;
	localparam logic [7:0] A_OMSK = 8'h28;
	localparam logic [7:0] A_OCTL = 8'h2C;
	localparam logic [7:0] A_ODLO = 8'h30;
	localparam logic [7:0] A_ODHI = 8'h34;
	// control register fields
	localparam int C_INIT = 0;
	localparam int C_NORT = 5;
	localparam int C_CFG  = 6;
	localparam int C_TEST = 7;
	localparam int C_AREC = 9;
	// test register fields
	localparam int T_SIL = 3;
	localparam int T_LB  = 4;
	localparam int T_RXP = 7;
	localparam int T_XLB = 8;
	// status and error counter fields
	localparam int S_LEC  = 0;
	localparam int S_BOFF = 7;
	localparam int S_REC  = 8;
	localparam int S_ON   = 9;
	localparam int E_TEC  = 0;
	localparam int E_REC  = 16;
	// object control fields
	localparam int O_VAL = 0;
	localparam int O_TX  = 1;
	localparam int O_RMT = 2;
	localparam int O_REQ = 3;
	localparam int O_DLC = 8;
	// sizes
	localparam int NOBJ = 32;
	localparam int OIW  = 5;
	localparam int IDW  = 29;
	localparam int BTW  = 16;
	// reset values
	localparam logic            INIT_RST = 1'h1;
	localparam logic [BTW-1:0]  BTR_RST  = 16'h0000;
	localparam logic [31:0]     ABOD_RST = 32'h0000_0000;
	// protocol counts and codes
	localparam logic [3:0]      IDLE_RUN   = 4'hB;
	localparam logic [7:0]      RECOV_SEQS = 8'h81;
	localparam logic [9:0]      TEC_LIM    = 10'h100;
	localparam logic [2:0]      LEC_BIT0   = 3'h5;

	typedef enum logic [2:0] {
		ST_INIT   = 3'b000,
		ST_SYNC   = 3'b001,
		ST_ACTIVE = 3'b010,
		ST_BOFF   = 3'b011,
		ST_RECOV  = 3'b100
	} cmc_state_t;

	typedef struct packed {
		logic           valid;
		logic           tx;
		logic           rmt;
		logic           req;
		logic [3:0]     dlc;
		logic [IDW-1:0] id;
		logic [IDW-1:0] mask;
		logic [63:0]    data;
	} cmc_obj_t;
endpackage

/* logic/cmc_obj_store.sv */
`timescale 1ns/10ps
module cmc_obj_store (
	// clock, reset, enable
	input  logic                    core_clk,
	input  logic                    reset_n,
	input  logic                    clk_en,
	// mode
	input  logic                    xfer_en,
	input  logic                    no_auto_retransmit,
	// register window
	input  logic [7:0]              reg_addr,
	input  logic [31:0]             reg_wdata,
	input  logic                    reg_wr,
	output logic [31:0]             obj_rdata,
	// receive side
	input  logic                    rx_id_ready,
	input  logic                    rx_remote,
	input  logic [cmc_pkg::IDW-1:0] rx_id,
	input  logic [3:0]              rx_dlc,
	input  logic [63:0]             rx_data,
	input  logic                    rx_done,
	// transmit side
	output logic                    tx_request,
	input  logic                    tx_start,
	input  logic                    tx_ok,
	input  logic                    tx_fail,
	output logic [cmc_pkg::IDW-1:0] tx_id,
	output logic [3:0]              tx_dlc,
	output logic [63:0]             tx_data
);
	import cmc_pkg::*;

	typedef struct packed {
		cmc_obj_t [NOBJ-1:0] o;
		logic [OIW-1:0]      sel;
		logic [OIW-1:0]      found;
		logic                hit;
		logic [OIW-1:0]      act;
		logic                busy;
		logic [IDW-1:0]      tid;
		logic [3:0]          tdlc;
		logic [63:0]         tdat;
	} cmc_ost_t;

	cmc_ost_t        st_ff;
	cmc_ost_t        nxt_st;
	logic [NOBJ-1:0] hit_v;
	logic [NOBJ-1:0] lim_v;
	logic [NOBJ-1:0] want_v;
	logic [OIW:0]    id_pick;
	logic [OIW:0]    rx_pick;
	logic [OIW:0]    tx_pick;
	cmc_obj_t        cur;

	// lowest set index wins, msb flags a hit
	function automatic logic [OIW:0] first_of(input logic [NOBJ-1:0] v);
		logic [OIW:0] r;
		r = '0;
		for (int i = NOBJ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, OIW'(i)};
			end
		end
		return r;
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < NOBJ; gi++) begin : g_obj
			assign hit_v[gi] = st_ff.o[gi].valid
				&& (rx_remote ? (st_ff.o[gi].tx && st_ff.o[gi].rmt) : !st_ff.o[gi].tx)
				&& (((st_ff.o[gi].id ^ rx_id) & st_ff.o[gi].mask) == '0);
			assign lim_v[gi] = (OIW'(gi) <= st_ff.found);
			assign want_v[gi] = st_ff.o[gi].valid && st_ff.o[gi].req;
		end
	endgenerate

	assign id_pick = first_of(hit_v);
	assign rx_pick = first_of(hit_v & lim_v);
	assign tx_pick = first_of(want_v);
	assign cur = st_ff.o[st_ff.sel];
	assign tx_request = xfer_en && !st_ff.busy && tx_pick[OIW];
	assign tx_id = st_ff.tid;
	assign tx_dlc = st_ff.tdlc;
	assign tx_data = st_ff.tdat;

	always_comb begin
		obj_rdata = '0;
		case (reg_addr)
			A_OSEL: obj_rdata[OIW-1:0] = st_ff.sel;
			A_OID:  obj_rdata[IDW-1:0] = cur.id;
			A_OMSK: obj_rdata[IDW-1:0] = cur.mask;
			A_OCTL: obj_rdata = {20'h00000, cur.dlc, 4'h0, cur.req, cur.rmt, cur.tx, cur.valid};
			A_ODLO: obj_rdata = cur.data[31:0];
			A_ODHI: obj_rdata = cur.data[63:32];
			default: obj_rdata = '0;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		if (!xfer_en) begin
			nxt_st.hit = 1'b0;
			nxt_st.busy = 1'b0;
		end else begin
			if (rx_id_ready) begin
				nxt_st.found = id_pick[OIW-1:0];
				nxt_st.hit = id_pick[OIW];
			end
			if (rx_done) begin
				nxt_st.hit = 1'b0;
				if (st_ff.hit && rx_pick[OIW]) begin
					if (rx_remote) begin
						nxt_st.o[rx_pick[OIW-1:0]].req = 1'b1;
					end else begin
						nxt_st.o[rx_pick[OIW-1:0]].id = rx_id;
						nxt_st.o[rx_pick[OIW-1:0]].dlc = rx_dlc;
						nxt_st.o[rx_pick[OIW-1:0]].data = rx_data;
					end
				end
			end
			// data is taken only when the frame starts
			if (tx_start && tx_request) begin
				nxt_st.busy = 1'b1;
				nxt_st.act = tx_pick[OIW-1:0];
				nxt_st.tid = st_ff.o[tx_pick[OIW-1:0]].id;
				nxt_st.tdlc = st_ff.o[tx_pick[OIW-1:0]].dlc;
				nxt_st.tdat = st_ff.o[tx_pick[OIW-1:0]].data;
			end
			if (st_ff.busy && tx_ok) begin
				nxt_st.busy = 1'b0;
				nxt_st.o[st_ff.act].req = 1'b0;
			end
			if (st_ff.busy && tx_fail) begin
				nxt_st.busy = 1'b0;
				nxt_st.o[st_ff.act].req = !no_auto_retransmit;
			end
		end
		if (reg_wr) begin
			case (reg_addr)
				A_OSEL: nxt_st.sel = reg_wdata[OIW-1:0];
				A_OID:  nxt_st.o[st_ff.sel].id = reg_wdata[IDW-1:0];
				A_OMSK: nxt_st.o[st_ff.sel].mask = reg_wdata[IDW-1:0];
				A_OCTL: begin
					nxt_st.o[st_ff.sel].valid = reg_wdata[O_VAL];
					nxt_st.o[st_ff.sel].tx = reg_wdata[O_TX];
					nxt_st.o[st_ff.sel].rmt = reg_wdata[O_RMT];
					nxt_st.o[st_ff.sel].req = reg_wdata[O_REQ];
					nxt_st.o[st_ff.sel].dlc = reg_wdata[O_DLC+3:O_DLC];
				end
				A_ODLO: nxt_st.o[st_ff.sel].data[31:0] = reg_wdata;
				A_ODHI: nxt_st.o[st_ff.sel].data[63:32] = reg_wdata;
				default: nxt_st.sel = st_ff.sel;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st_ff <= '0;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end
endmodule // cmc_obj_store

/* verification/cmc_mode_ctrl_assertions.sv */
`timescale 1ns/10ps
module cmc_mode_ctrl_assertions (
	// clock and reset
	input logic                    core_clk,
	input logic                    reset_n,
	// register writes
	input logic [7:0]              reg_addr,
	input logic [31:0]             reg_wdata,
	input logic                    reg_wr,
	// bit path
	input logic                    can_tx_pin,
	input logic                    core_tx,
	input logic                    core_rx,
	input logic                    bit_tick,
	// mode outputs and transmit handshake
	input logic                    core_enable,
	input logic                    ack_err_ignore,
	input logic                    auto_retransmit,
	input logic [cmc_pkg::BTW-1:0] bit_timing,
	input logic                    bus_off,
	input logic                    tx_request,
	input logic                    tx_start
);
	import cmc_pkg::*;
	logic [3:0]     run_ff;
	logic [10:0]    idle_ff;
	logic [1:0]     ctl_ff;
	logic [BTW-1:0] wlow;
	logic           nort_w;
	assign wlow   = reg_wdata[BTW-1:0];
	assign nort_w = reg_wdata[C_NORT];
	// recessive run length, idle bits seen in bus-off, software view of config enable and init
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			run_ff  <= 4'h0;
			idle_ff <= 11'h000;
			ctl_ff  <= 2'h1;
		end else begin
			if (bit_tick)
				run_ff <= !core_rx ? 4'h0 : (run_ff == 4'hF ? run_ff : run_ff + 4'h1);
			if (!bus_off)
				idle_ff <= 11'h000;
			else if (bit_tick && core_rx && idle_ff != 11'h7FF)
				idle_ff <= idle_ff + 11'h001;
			if (reg_wr && reg_addr == A_CTL)
				ctl_ff <= {reg_wdata[C_CFG], reg_wdata[C_INIT]};
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_rst;
		disable iff (1'b0) !reset_n |=> can_tx_pin && !core_enable && !bus_off;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_idle;
		!core_enable [*2] |-> can_tx_pin;
	endproperty
	a_idle: assert property (p_idle) else $error("dominant while idle");
	property p_btr_lock;
		reg_wr && reg_addr == A_BTR && !ctl_ff[1] |=> $stable(bit_timing);
	endproperty
	a_btr_lock: assert property (p_btr_lock) else $error("timing written while locked");
	property p_btr_take;
		reg_wr && reg_addr == A_BTR && ctl_ff == 2'h3 |=> bit_timing == $past(wlow);
	endproperty
	a_btr_take: assert property (p_btr_take) else $error("timing write lost");
	property p_dar;
		reg_wr && reg_addr == A_CTL |=> auto_retransmit != $past(nort_w);
	endproperty
	a_dar: assert property (p_dar) else $error("retransmit flag wrong");
	property p_sync;
		$rose(core_enable) |-> run_ff >= 4'hB;
	endproperty
	a_sync: assert property (p_sync) else $error("joined bus too early");
	property p_recov;
		$fell(bus_off) |-> idle_ff >= 11'h58B;
	endproperty
	a_recov: assert property (p_recov) else $error("recovery too short");
	property p_boff;
		bus_off |-> !core_enable;
	endproperty
	a_boff: assert property (p_boff) else $error("active in bus-off");
	property p_internal_loopback;
		ack_err_ignore |=> core_rx == $past(core_tx);
	endproperty
	a_internal_loopback: assert property (p_internal_loopback) else $error("loopback path wrong");
	property p_txreq;
		tx_start && tx_request && core_enable |=> !tx_request;
	endproperty
	a_txreq: assert property (p_txreq) else $error("request kept after start");
endmodule // cmc_mode_ctrl_assertions

bind cmc_mode_ctrl cmc_mode_ctrl_assertions u_cmc_mode_ctrl_assertions (.core_clk, .reset_n, .reg_addr,
	.reg_wdata, .reg_wr, .can_tx_pin, .core_tx, .core_rx, .bit_tick, .core_enable, .ack_err_ignore,
	.auto_retransmit, .bit_timing, .bus_off, .tx_request, .tx_start);

/* verification/cmc_bus_node.sv */
`timescale 1ns/10ps
module cmc_bus_node (
	// device pins
	input  logic can_tx_pin,
	output logic can_rx_pin,
	output logic can_tx_pad_in,
	// other nodes
	input  logic drive_dominant
);
	// wired-and bus through the transceiver: any zero wins
	assign can_rx_pin    = can_tx_pin & ~drive_dominant;
	// pad buffer sees only the device's own driver
	assign can_tx_pad_in = can_tx_pin;
endmodule // cmc_bus_node

/* verification/cmc_mode_ctrl_bench.sv */
`timescale 1ns/10ps
module cmc_mode_ctrl_bench;
	import cmc_pkg::*;
	logic core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic core_tx = 1'b1, bit_tick = 1'b0, tec_dec = 1'b0, rec_dec = 1'b0, lec_valid = 1'b0;
	logic rx_id_ready = 1'b0, rx_remote = 1'b0, rx_done = 1'b0, tx_start = 1'b0, tx_ok = 1'b0;
	logic tx_fail = 1'b0, dom = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [3:0] tec_inc = 4'h0, rec_inc = 4'h0, rx_dlc = 4'h0;
	logic [2:0] lec_code = 3'h0;
	logic [IDW-1:0] rx_id = '0;
	logic [63:0] rx_data = 64'h0;
	logic can_rx_pin, can_tx_pad_in, can_tx_pin, core_rx, core_enable;
	logic ack_err_ignore, auto_retransmit, bus_off, tx_request;
	logic [BTW-1:0] bit_timing;
	logic [IDW-1:0] tx_id;
	logic [3:0] tx_dlc;
	logic [63:0] tx_data, tx_exp;
	logic [31:0] reg_rdata, d, v;
	logic [1:0] e;
	int seed = 32'hE637;
	int bad_count = 0;
	int n_compared = 0;
	logic [31:0] modes [7] = '{32'h0, 32'h8, 32'h10, 32'h100, 32'h110, 32'h18, 32'h8000_0010};

	cmc_mode_ctrl u_cmc_mode_ctrl (.core_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .can_tx_pin, .can_rx_pin, .can_tx_pad_in, .core_tx, .core_rx, .bit_tick, .core_enable,
		.ack_err_ignore, .auto_retransmit, .bit_timing, .bus_off, .tec_inc, .tec_dec, .rec_inc, .rec_dec,
		.lec_valid, .lec_code, .rx_id_ready, .rx_remote, .rx_id, .rx_dlc, .rx_data, .rx_done, .tx_request,
		.tx_start, .tx_ok, .tx_fail, .tx_id, .tx_dlc, .tx_data);
	cmc_bus_node u_cmc_bus_node (.can_tx_pin, .can_rx_pin, .can_tx_pad_in, .drive_dominant(dom));

	always #4 core_clk = ~core_clk;

	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, x);
	endtask
	// recessive or dominant bus, then n bit samples
	task automatic ticks(input int n, input logic lvl);
		@(posedge core_clk);
		dom <= ~lvl;
		@(posedge core_clk);
		repeat (n) begin
			@(posedge core_clk);
			bit_tick <= 1'b1;
			@(posedge core_clk);
			bit_tick <= 1'b0;
		end
		#1;
	endtask
	task automatic wait_on(input int s, input logic x);
		int i;
		for (i = 0; i < 40 && (s == 0 ? bus_off : (s == 1 ? tx_request : core_enable)) !== x; i++)
			step(1);
		if (i == 40) begin
			bad_count++;
			complete_run();
		end
	endtask
	task automatic pulse_tx(input logic ok);
		@(posedge core_clk);
		tx_start <= ~ok;
		tx_ok <= ok;
		@(posedge core_clk);
		tx_start <= 1'b0;
		tx_ok <= 1'b0;
		#1;
	endtask
	// one received frame: identifier known, then frame done
	task automatic rx_frame(input logic rm);
		@(posedge core_clk);
		rx_remote <= rm;
		rx_id_ready <= 1'b1;
		@(posedge core_clk);
		rx_id_ready <= 1'b0;
		rx_done <= 1'b1;
		@(posedge core_clk);
		rx_done <= 1'b0;
		#1;
	endtask
	task automatic burst();
		@(posedge core_clk);
		tec_inc <= 4'h8;
		repeat (32) @(posedge core_clk);
		tec_inc <= 4'h0;
		wait_on(0, 1'b1);
	endtask
	// pin level and core input for a test setup
	function automatic logic [1:0] bit_path(input logic [31:0] m, input logic tx, input logic dm);
		logic te, pin;
		te = !m[31];
		pin = (te && m[T_SIL]) ? 1'b1 : tx;
		if (te && m[T_LB])
			return {pin, tx};
		if (te && m[T_XLB])
			return {pin, pin};
		return {pin, pin & tx & ~dm};
	endfunction

	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		step(1);
		chk({can_tx_pin, core_enable, bus_off, auto_retransmit}, 4'h9);
		rdchk(A_CTL, 32'hFFFF_FFFF, 32'h1);
		rdchk(8'h3C, 32'hFFFF_FFFF, 32'h0);
		wr(8'h3C, 32'hFFFF_FFFF);
		$display("reset values done");
		v = $random(seed);
		wr(A_BTR, v);
		rdchk(A_BTR, 32'hFFFF, BTR_RST);
		wr(A_CTL, 32'h41);
		wr(A_BTR, v);
		wr(A_CTL, 32'h21);
		chk(bit_timing, v[15:0]);
		rdchk(A_BTR, 32'hFFFF, v & 32'hFFFF);
		chk(auto_retransmit, 1'b0);
		wr(A_CTL, 32'h1);
		chk(auto_retransmit, 1'b1);
		@(posedge core_clk);
		{tec_inc, rec_inc, lec_valid, lec_code} <= 12'h44B;
		@(posedge core_clk);
		{tec_inc, rec_inc, lec_valid} <= 9'h0;
		rdchk(A_ERRC, 32'hFF01FF, 32'h0);
		rdchk(A_STAT, 32'h7, 32'h0);
		$display("init checks done");
		wr(A_CTL, 32'h0);
		ticks(6, 1'b1);
		ticks(1, 1'b0);
		ticks(10, 1'b1);
		chk(core_enable, 1'b0);
		ticks(1, 1'b1);
		chk(core_enable, 1'b1);
		wr(A_TEST, 32'h118);
		rdchk(A_TEST, 32'h118, 32'h0);
		foreach (modes[k]) begin
			wr(A_CTL, modes[k][31] ? 32'h0 : 32'h80);
			wr(A_TEST, modes[k]);
			step(1);
			chk(ack_err_ignore, !modes[k][31] && modes[k][T_LB]);
			repeat (6) begin
				@(posedge core_clk);
				core_tx <= 1'($random(seed));
				dom <= 1'($random(seed));
				step(2);
				e = bit_path(modes[k], core_tx, dom);
				chk({can_tx_pin, core_rx}, e);
			end
		end
		@(posedge core_clk);
		core_tx <= 1'b1;
		dom <= 1'b0;
		$display("bit path modes done");
		// object 0 takes any data frame; others stay as reset left them
		wr(A_OSEL, 32'h0);
		wr(A_OMSK, 32'h0);
		wr(A_OCTL, 32'h1);
		@(posedge core_clk);
		rx_id <= IDW'($random(seed));
		rx_dlc <= 4'h8;
		rx_data <= {$random(seed), $random(seed)};
		rx_frame(1'b0);
		rdchk(A_OID, 32'hFFFF_FFFF, {3'h0, rx_id});
		rdchk(A_ODHI, 32'hFFFF_FFFF, rx_data[63:32]);
		rdchk(A_OCTL, 32'hF00, 32'h800);
		for (int k = 2; k > 0; k--) begin
			wr(A_OSEL, 32'(k));
			wr(A_OID, 32'h100 * k);
			wr(A_ODLO, 32'h0);
			wr(A_OCTL, 32'h80B);
		end
		v = $random(seed);
		wr(A_OSEL, 32'h2);
		wr(A_ODLO, v);
		for (int k = 1; k < 3; k++) begin
			wait_on(1, 1'b1);
			pulse_tx(1'b0);
			tx_exp = {32'h0, k == 2 ? v : 32'h0};
			chk(tx_id, 32'h100 * k);
			chk(tx_data, tx_exp);
			chk(tx_dlc, 4'h8);
			pulse_tx(1'b1);
		end
		// object 1 answers remote frames; a matching one raises its request
		wr(A_OSEL, 32'h1);
		wr(A_OCTL, 32'h807);
		rx_frame(1'b1);
		rdchk(A_OCTL, 32'hF, 32'hF);
		$display("objects done");
		burst();
		step(1);
		chk({core_enable, can_tx_pin}, 2'h1);
		rdchk(A_CTL, 32'h1, 32'h1);
		wr(A_CTL, 32'h0);
		ticks(11, 1'b1);
		rdchk(A_STAT, 32'h87, {24'h0, 5'h10, LEC_BIT0});
		wr(A_CTL, 32'h1);
		wr(A_CTL, 32'h0);
		ticks(129 * 11 - 12, 1'b1);
		chk(bus_off, 1'b1);
		ticks(1, 1'b1);
		wait_on(0, 1'b0);
		rdchk(A_ERRC, 32'hFF01FF, 32'h0);
		ticks(11, 1'b1);
		wait_on(2, 1'b1);
		$display("recovery done");
		wr(A_ABOD, 32'h3);
		wr(A_CTL, 32'h200);
		burst();
		step(8);
		rdchk(A_STAT, 32'h180, 32'h180);
		$display("auto recovery done");
		complete_run();
	end
	initial begin
		#400000;
		bad_count++;
		complete_run();
	end
endmodule // cmc_mode_ctrl_bench
